/* inc/nlcorr_pkg.sv */
// Package of register map, reset values and carrier types for the phase nonlinearity coefficient bank.
`default_nettype none
package nlcorr_pkg;
  // ==========================================================================
  // Register bus widths and register offsets
  localparam int NLC_AW = 8;
  localparam int NLC_DW = 24;
  localparam int NLC_CW = 16;
  localparam logic [NLC_AW-1:0] NLC_OFS_CTRL = 8'h4a;
  localparam logic [NLC_AW-1:0] NLC_OFS_FIRST = 8'h4b;
  localparam logic [NLC_AW-1:0] NLC_OFS_SECOND = 8'h4c;
  localparam logic [NLC_AW-1:0] NLC_OFS_THIRD = 8'h4d;
  localparam logic [NLC_AW-1:0] NLC_OFS_FOURTH = 8'h4e;

  // ==========================================================================
  // Field positions inside the control register
  localparam int NLC_EN_BIT = 0;
  localparam int NLC_A0_LSB = 2;
  localparam int NLC_SCALE_LSB = 18;
  localparam int NLC_SCALE_W = 2;

  // ==========================================================================
  // Reset values of the fields
  localparam logic NLC_RST_EN = 1'b0;
  localparam logic [NLC_SCALE_W-1:0] NLC_RST_SCALE = 2'h0;
  localparam logic [NLC_CW-1:0] NLC_RST_A0 = 16'h0000;
  localparam logic [NLC_CW-1:0] NLC_RST_A1 = 16'h0407;
  localparam logic [NLC_CW-1:0] NLC_RST_A2 = 16'hf23e;
  localparam logic [NLC_CW-1:0] NLC_RST_A3 = 16'h1144;
  localparam logic [NLC_CW-1:0] NLC_RST_A4 = 16'hf881;
  localparam logic [NLC_DW-1:0] NLC_ZERO_WORD = 24'h00_0000;

  // ==========================================================================
  // Phase arithmetic limits
  localparam int NLC_SUM_W = 21;
  localparam logic [NLC_CW-1:0] NLC_PHASE_MAX = 16'hffff;
  localparam logic [NLC_CW-1:0] NLC_PHASE_MIN = 16'h0000;

  // Whole contents of the bank, carried together.
  typedef struct packed {
    logic enable;
    logic [NLC_SCALE_W-1:0] scale;
    logic [NLC_CW-1:0] a0;
    logic [NLC_CW-1:0] a1;
    logic [NLC_CW-1:0] a2;
    logic [NLC_CW-1:0] a3;
    logic [NLC_CW-1:0] a4;
  } nlc_bank_s;

  localparam nlc_bank_s NLC_BANK_RESET = '{
    enable: NLC_RST_EN, scale: NLC_RST_SCALE, a0: NLC_RST_A0,
    a1: NLC_RST_A1, a2: NLC_RST_A2, a3: NLC_RST_A3, a4: NLC_RST_A4};

  // Phase sample with its strobe.
  typedef struct packed {
    logic valid;
    logic [NLC_CW-1:0] phase;
  } nlc_phase_s;
endpackage
`default_nettype wire

/* core/nlcorr_regs.sv */
// Phase nonlinearity coefficient bank with its register port and zeroth-order correction stage.
`default_nettype none
module nlcorr_regs
  import nlcorr_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // Register port from the serial control interface
  input wire logic [NLC_AW-1:0] REG_ADDR_IN,
  input wire logic [NLC_DW-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [NLC_DW-1:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // Overflow mode from the clip-mode register
  input wire logic NL_SATURATE_SELECT_IN,
  // Phase stream
  input wire logic [NLC_CW-1:0] PHASE_IN,
  input wire logic PHASE_VALID_IN,
  output logic [NLC_CW-1:0] PHASE_OUT,
  output logic PHASE_VALID_OUT,
  // Bank contents for the downstream polynomial stage
  output var nlc_bank_s COEFF_BANK_OUT
);

  // ==========================================================================
  // Helper functions

  // Read word for an offset; reserved and unmapped bits come back as zero.
  function automatic logic [NLC_DW-1:0] read_word(input logic [NLC_AW-1:0] addr, input nlc_bank_s b);
    logic [NLC_DW-1:0] w;
    w = NLC_ZERO_WORD;
    unique case (addr)
      NLC_OFS_CTRL: begin
        w[NLC_EN_BIT] = b.enable;
        w[NLC_A0_LSB +: NLC_CW] = b.a0;
        w[NLC_SCALE_LSB +: NLC_SCALE_W] = b.scale;
      end
      NLC_OFS_FIRST: w[NLC_CW-1:0] = b.a1;
      NLC_OFS_SECOND: w[NLC_CW-1:0] = b.a2;
      NLC_OFS_THIRD: w[NLC_CW-1:0] = b.a3;
      NLC_OFS_FOURTH: w[NLC_CW-1:0] = b.a4;
      default: w = NLC_ZERO_WORD;
    endcase
    return w;
  endfunction

  // Phase plus the scaled signed zeroth-order term, in a wide signed sum.
  function automatic logic signed [NLC_SUM_W-1:0] corr_sum(input logic [NLC_CW-1:0] ph,
                                                          input logic [NLC_CW-1:0] a0,
                                                          input logic [NLC_SCALE_W-1:0] sc);
    logic signed [NLC_SUM_W-1:0] ofs;
    ofs = NLC_SUM_W'(signed'(a0));
    ofs = ofs <<< sc;
    return NLC_SUM_W'(signed'({1'b0, ph})) + ofs;
  endfunction

  // ==========================================================================
  // Register bank state
  nlc_bank_s bank_reg, bank_next;
  logic [NLC_DW-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // Writes land on the edge that takes them; reserved bits of the word are dropped.
  always_comb begin
    bank_next = bank_reg;
    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        NLC_OFS_CTRL: begin
          bank_next.enable = REG_WDATA_IN[NLC_EN_BIT];
          bank_next.scale = REG_WDATA_IN[NLC_SCALE_LSB +: NLC_SCALE_W];
          bank_next.a0 = REG_WDATA_IN[NLC_A0_LSB +: NLC_CW];
        end
        NLC_OFS_FIRST: bank_next.a1 = REG_WDATA_IN[NLC_CW-1:0];
        NLC_OFS_SECOND: bank_next.a2 = REG_WDATA_IN[NLC_CW-1:0];
        NLC_OFS_THIRD: bank_next.a3 = REG_WDATA_IN[NLC_CW-1:0];
        NLC_OFS_FOURTH: bank_next.a4 = REG_WDATA_IN[NLC_CW-1:0];
        default: bank_next = bank_reg;
      endcase
    end
  end

  // Read answers one cycle after the strobe; a read of an unmapped offset answers zero.
  always_comb begin
    rvalid_next = REG_RD_IN;
    rdata_next = rdata_reg;
    if (REG_RD_IN) begin
      rdata_next = read_word(REG_ADDR_IN, bank_reg);
    end
  end

  // Bank and read registers.
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      bank_reg <= NLC_BANK_RESET;
      rdata_reg <= NLC_ZERO_WORD;
      rvalid_reg <= 1'b0;
    end else begin
      bank_reg <= bank_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ==========================================================================
  // Correction stage
  nlc_phase_s out_reg, out_next;
  logic signed [NLC_SUM_W-1:0] sum_w;

  // Only the zeroth-order term is applied here; the higher orders go out on the bank port
  // because the polynomial arithmetic lives in the downstream stage.
  always_comb begin
    sum_w = corr_sum(PHASE_IN, bank_reg.a0, bank_reg.scale);
    out_next.valid = PHASE_VALID_IN;
    out_next.phase = out_reg.phase;
    if (PHASE_VALID_IN) begin
      if (!bank_reg.enable) begin
        out_next.phase = PHASE_IN;
      end else if (!NL_SATURATE_SELECT_IN) begin
        out_next.phase = sum_w[NLC_CW-1:0];
      end else if (sum_w < 0) begin
        out_next.phase = NLC_PHASE_MIN;
      end else if (sum_w > NLC_SUM_W'(NLC_PHASE_MAX)) begin
        out_next.phase = NLC_PHASE_MAX; // Clip at the ceiling.
      end else begin
        out_next.phase = sum_w[NLC_CW-1:0];
      end
    end
  end

  // Output phase register.
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  // ==========================================================================
  // Output drive, all straight from flip-flops
  assign REG_RDATA_OUT = rdata_reg;
  assign REG_RVALID_OUT = rvalid_reg;
  assign PHASE_OUT = out_reg.phase;
  assign PHASE_VALID_OUT = out_reg.valid;
  assign COEFF_BANK_OUT = bank_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence ctrl_write_s;
    REG_WR_IN && REG_ADDR_IN == NLC_OFS_CTRL;
  endsequence

  sequence read_of_s(logic [NLC_AW-1:0] ofs);
    REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == ofs;
  endsequence

  bypass_when_off_a: assert property (PHASE_VALID_IN && !bank_reg.enable |=>
      PHASE_VALID_OUT && PHASE_OUT == $past(PHASE_IN))
    else $error("phase changed while correction disabled");
  zero_term_on_a: assert property (PHASE_VALID_IN && bank_reg.enable && bank_reg.a0 == NLC_RST_A0 |=>
      PHASE_OUT == $past(PHASE_IN))
    else $error("zero offset altered enabled phase");
  scale_field_a: assert property (ctrl_write_s ##1 read_of_s(NLC_OFS_CTRL) |=>
      REG_RDATA_OUT[NLC_SCALE_LSB +: NLC_SCALE_W] == $past(REG_WDATA_IN[NLC_SCALE_LSB +: NLC_SCALE_W], 2))
    else $error("scale field did not hold written value");
  zeroth_coeff_a: assert property (ctrl_write_s |=> bank_reg.a0 == $past(REG_WDATA_IN[NLC_A0_LSB +: NLC_CW])
      && bank_reg.enable == $past(REG_WDATA_IN[NLC_EN_BIT]))
    else $error("control register write lost");
  first_coeff_a: assert property (REG_WR_IN && REG_ADDR_IN == NLC_OFS_FIRST |=>
      COEFF_BANK_OUT.a1 == $past(REG_WDATA_IN[NLC_CW-1:0]))
    else $error("first coefficient write lost");
  second_read_a: assert property (read_of_s(NLC_OFS_SECOND) |=>
      REG_RVALID_OUT && REG_RDATA_OUT == {8'h00, $past(bank_reg.a2)})
    else $error("second coefficient read wrong");
  third_coeff_a: assert property (REG_WR_IN && REG_ADDR_IN == NLC_OFS_THIRD ##1 read_of_s(NLC_OFS_THIRD) |=>
      REG_RDATA_OUT[NLC_CW-1:0] == $past(REG_WDATA_IN[NLC_CW-1:0], 2))
    else $error("third coefficient readback wrong");
  fourth_read_a: assert property (read_of_s(NLC_OFS_FOURTH) |=>
      REG_RDATA_OUT == {8'h00, $past(bank_reg.a4)})
    else $error("fourth coefficient read wrong");
  // The control word keeps bits 23:20 and 1 free; the coefficient words keep their upper byte free.
  reserved_zero_a: assert property (REG_RD_IN |=> REG_RVALID_OUT
      && ($past(REG_ADDR_IN) == NLC_OFS_CTRL ? REG_RDATA_OUT[NLC_DW-1:NLC_SCALE_LSB+NLC_SCALE_W] == '0
          && REG_RDATA_OUT[NLC_EN_BIT+1] == 1'b0 : REG_RDATA_OUT[NLC_DW-1:NLC_CW] == '0))
    else $error("reserved bits read non-zero");
  clip_floor_a: assert property (PHASE_VALID_IN && bank_reg.enable && NL_SATURATE_SELECT_IN && sum_w < 0 |=>
      PHASE_OUT == NLC_PHASE_MIN)
    else $error("negative corrected phase not clipped");
  // Modulo arithmetic in the phase width, kept apart from the wide sum that the stage uses.
  wrap_mode_a: assert property (PHASE_VALID_IN && bank_reg.enable && !NL_SATURATE_SELECT_IN |=>
      PHASE_OUT == $past(NLC_CW'(PHASE_IN + (bank_reg.a0 << bank_reg.scale))))
    else $error("wrap mode result wrong");
endmodule
`default_nettype wire

/* verif/nlcorr_regs_test.sv */
// Self-checking bench for the phase nonlinearity coefficient bank and its correction stage.
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %0h, expected %0h", $time, a, b); end end
module nlcorr_regs_test
  import nlcorr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus signals and design instance
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NLC_AW-1:0] reg_addr = 8'h00;
  logic [NLC_DW-1:0] reg_wdata = 24'h00_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sat = 1'b0;
  logic [NLC_CW-1:0] ph_in = 16'h0000;
  logic ph_vld = 1'b0;
  logic [NLC_DW-1:0] rdata;
  logic rvalid;
  logic [NLC_CW-1:0] ph_out;
  logic ph_vld_out;
  nlc_bank_s bank;
  int errors = 0;
  int checked = 0;
  logic [NLC_DW-1:0] rst_tab [5] = '{24'h00_0000, 24'h00_0407, 24'h00_f23e, 24'h00_1144, 24'h00_f881};
  logic [NLC_CW-1:0] a0_tab [2] = '{16'h0010, 16'hfff0};
  logic [NLC_CW-1:0] p_tab [2] = '{16'hfff8, 16'h0004};

  nlcorr_regs dut (.MCLK_IN(clk), .RSTN_IN(rst_n), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
    .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .NL_SATURATE_SELECT_IN(sat), .PHASE_IN(ph_in), .PHASE_VALID_IN(ph_vld), .PHASE_OUT(ph_out),
    .PHASE_VALID_OUT(ph_vld_out), .COEFF_BANK_OUT(bank));

  // The 250 MHz device clock.
  initial begin
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Access tasks; each starts one edge later, so no strobe is set twice in one step.
  task automatic wr(input logic [NLC_AW-1:0] a, input logic [NLC_DW-1:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  // The read valid stands for one cycle only, so the answer is looked at right after the taking edge.
  task automatic rd(input logic [NLC_AW-1:0] a, input logic [NLC_DW-1:0] e);
    @(posedge clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask

  // A write and a read of the same place on two neighbouring edges; the answer then drops after one cycle.
  task automatic wr_rd(input logic [NLC_AW-1:0] a, input logic [NLC_DW-1:0] d, input logic [NLC_DW-1:0] e);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
    @(posedge clk);
    #1 `CHK(rvalid, 1'b0)
  endtask

  task automatic ph(input logic [NLC_CW-1:0] p, input logic [NLC_CW-1:0] e);
    @(posedge clk);
    #1 ph_in = p;
    ph_vld = 1'b1;
    @(posedge clk);
    #1 ph_vld = 1'b0;
    `CHK(ph_vld_out, 1'b1)
    `CHK(ph_out, e)
  endtask

  // Reference of the zeroth-order offset, scaled by a power of two, with wrap or clip.
  function automatic logic [NLC_CW-1:0] exp_ph(input logic [15:0] p, input logic [15:0] a0,
      input logic [1:0] sc, input logic s);
    logic signed [20:0] sum;
    sum = $signed({5'h00, p}) + ($signed({{5{a0[15]}}, a0}) <<< sc);
    if (s && sum < 0) return 16'h0000;
    if (s && sum > 21'sh0_ffff) return 16'hffff;
    return sum[15:0];
  endfunction

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d errors", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(NLC_OFS_CTRL + 8'(i), rst_tab[i]);
    end
    `CHK(bank, {1'b0, 2'h0, 16'h0000, 16'h0407, 16'hf23e, 16'h1144, 16'hf881})
    $display("Test reset values done");
    // reserved bits read zero; unmapped places hold nothing.
    wr(8'h49, 24'hff_ffff);
    rd(8'h49, 24'h00_0000);
    rd(8'h4f, 24'h00_0000);
    wr(NLC_OFS_CTRL, 24'hff_ffff);
    rd(NLC_OFS_CTRL, 24'h0f_fffd);
    for (int i = 1; i < 5; i++) begin
      wr(NLC_OFS_CTRL + 8'(i), 24'hff_ffff);
      rd(NLC_OFS_CTRL + 8'(i), 24'h00_ffff);
    end
    $display("Test reserved bits done");
    // A read in the cycle of a write to the same place still returns the old word.
    @(posedge clk);
    #1 reg_addr = NLC_OFS_FIRST;
    reg_wdata = 24'h00_1234;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b0;
    `CHK(rdata, 24'h00_ffff)
    `CHK(bank.a1, 16'h1234)
    rd(NLC_OFS_FIRST, 24'h00_1234);
    $display("Test read during write done");
    // Back-to-back write and read, then a zero offset that must leave enabled phase untouched.
    wr_rd(NLC_OFS_CTRL, 24'h08_0001, 24'h08_0001);
    ph(16'h8765, 16'h8765);
    wr_rd(NLC_OFS_THIRD, 24'h00_5a5a, 24'h00_5a5a);
    $display("Test back-to-back access done");
    // pass-through with large coefficients while disabled, with clip mode selected.
    sat = 1'b1;
    wr(NLC_OFS_CTRL, 24'h0d_fffc);
    ph(16'h1234, 16'h1234);
    ph(16'hffff, 16'hffff);
    $display("Test disabled pass-through done");
    // every scale with both overflow modes, across both ends of the range.
    for (int sc = 0; sc < 4; sc++) begin
      for (int m = 0; m < 4; m++) begin
        sat = m[0];
        wr(NLC_OFS_CTRL, {4'h0, 2'(sc), a0_tab[m[1]], 2'b01});
        `CHK(bank.scale, 2'(sc))
        ph(p_tab[m[1]], exp_ph(p_tab[m[1]], a0_tab[m[1]], 2'(sc), m[0]));
      end
    end
    ph(16'h0100, 16'h0100 + (16'hfff0 << 3));
    $display("Test correction done");
    give_verdict();
  end
endmodule
`default_nettype wire
